// file: hw/timer2_clock_event_io.sv
// Summary of operation
// RULE1: Rate field divides clock by 1/4/32/256 (rate 0 divides by 2 here)
// RULE2: Event input sampled by system clock
// RULE3: Event mode counts chosen input edge
// RULE4: Event mode active edge sets flag
// RULE5: Gate mode counts prescaled clock while active
// RULE6: Gate mode trailing edge sets flag
// RULE7: Software presets counter after mode change
// RULE8: Software keeps input pin as input
// RULE9: Compare match toggles half-rate output stage
// RULE10: Counter write loads stage with edge select
// RULE11: Output enable changes at chosen output edge
// RULE12: Pin buffer on if direction or enable
// RULE13: Output off: pin follows latch or floats
// RULE14: Eight-bit prescaler feeds timers and input
// RULE15: First timer gets fixed-rate clock
// RULE16: Prescaled clock steps with system clock
// RULE17: Source select picks prescaled or input clock
// RULE18: Writing one to clear bit clears flag
// RULE19: Interrupt while flag and enable set
// RULE20: Counter increments on selected clock edge
// RULE21: Two-stage synchroniser before detection
//
// Local design decisions: the register addresses and the plain strobed port.
module timer2_clock_event_io
  import tmr2_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Register port
  input  wire logic [2:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Event input pin
  input  wire logic             event_input,
  // Shared event output pin
  output logic                  event_output_o,
  output logic                  event_output_oe,
  // Fixed-rate clock for the first timer
  output logic                  fixed_timer_clock,
  // Interrupt requests
  output logic                  input_irq,
  output logic                  compare_irq
);

  // Software-visible state
  logic [1:0]       rate_r;          // Prescale rate field
  logic [7:0]       ctl_r;           // Control byte
  logic [2:0]       port_r;          // Pin direction and latch
  logic [WIDTH-1:0] cnt_r;           // Counter
  logic [WIDTH-1:0] cmp_r;           // Compare register
  logic [WIDTH-1:0] cmp_buf_r;       // Compare buffer
  logic             evt_flag_r;      // Input event flag
  logic             cmp_flag_r;      // Compare flag
  // Prescaler and timer clock
  logic [DIV_BITS-1:0] pre_r;        // Free-running prescaler
  logic             pclk_r;          // Prescaled timer clock level
  logic             pclk_nxt;
  phase_t           pclk_ph_r;       // Previous phase of counter clock
  // Event input path
  logic             sync1_r;         // First synchroniser stage
  logic             sync2_r;         // Second synchroniser stage
  logic             sync3_r;         // Previous synchronised value
  // Event output path
  logic             div_r;           // Half-rate output stage
  logic             oe_sync_r;       // Synchronised output enable
  logic             match_r;         // Latched match, next timer cycle
  // Decoded strobes
  logic             wr_cnt;
  logic             act_lvl;
  logic             act_edge;
  logic             trail_edge;
  logic             gate_clk;
  logic             tclk;            // Selected counter clock level
  logic             tick;            // One counter step
  logic             cmp_pulse;       // compare_match_pulse
  logic             div_nxt;
  logic             sel_edge;

  // Address decode used by several write processes
  function automatic logic hit(input logic [2:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  assign wr_cnt = hit(ADDR_COUNTER);

  // Prescaler runs free; every divided clock except rate 0 is a tap of it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pre_r <= '0;
    end else if (clk_en) begin
      pre_r <= pre_r + 1'b1; // RULE14
    end
  end

  // Tap select; the level is registered so it moves on a system edge
  always_comb begin
    case (rate_r) // RULE1
      2'b00:   pclk_nxt = ~pclk_r;
      2'b01:   pclk_nxt = pre_r[TAP_DIV4];
      2'b10:   pclk_nxt = pre_r[TAP_DIV32];
      default: pclk_nxt = pre_r[TAP_DIV256];
    endcase
  end

  // Prescaled clock register and fixed first-timer clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pclk_r            <= 1'b0;
      fixed_timer_clock <= 1'b0;
    end else if (clk_en) begin
      pclk_r            <= pclk_nxt; // RULE16
      fixed_timer_clock <= pre_r[TAP_FIXED]; // RULE15
    end
  end

  // Two-flop synchroniser plus a history stage for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= event_input; // RULE2
      sync2_r <= sync1_r;     // RULE21
      sync3_r <= sync2_r;
    end
  end

  // Active level follows polarity; edges come from stages two and three
  assign act_lvl    = ctl_r[CTL_POL] ? sync2_r : ~sync2_r;
  assign act_edge   = ctl_r[CTL_POL] ? (sync2_r & ~sync3_r)
                                     : (~sync2_r & sync3_r); // RULE3
  assign trail_edge = ctl_r[CTL_POL] ? (~sync2_r & sync3_r)
                                     : (sync2_r & ~sync3_r); // RULE6
  // Gate mode: prescaled clock held high while input is inactive
  assign gate_clk   = act_lvl ? pclk_r : 1'b1; // RULE5

  // Counter clock: prescaled or event block output
  always_comb begin
    if (!ctl_r[CTL_SRC]) begin
      tclk = pclk_r; // RULE17
    end else if (ctl_r[CTL_MODE]) begin
      tclk = gate_clk;
    end else begin
      tclk = sync2_r ^ ctl_r[CTL_POL]; // Active edge becomes a fall
    end
  end

  // Falling edge of the timer clock gives one count step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pclk_ph_r <= PH_LOW;
    end else if (clk_en) begin
      pclk_ph_r <= tclk ? PH_HIGH : PH_LOW;
    end
  end

  always_comb begin
    case (pclk_ph_r)
      PH_HIGH: tick = ~tclk; // RULE20
      PH_LOW:  tick = 1'b0;
      default: tick = 1'b0;
    endcase
  end

  // Match is latched for a timer cycle and emitted on the next step
  assign cmp_pulse = tick & match_r;

  // Counter with preset; a preset beats an increment
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r     <= WIDTH'(CNT_PRESET);
      cmp_buf_r <= '0;
      match_r   <= 1'b0;
    end else if (clk_en) begin
      if (wr_cnt || cmp_pulse) begin
        // Mode changes can glitch a count; software presets here
        cnt_r     <= WIDTH'(CNT_PRESET); // RULE7
        cmp_buf_r <= cmp_r;
        match_r   <= 1'b0;
      end else if (tick) begin
        cnt_r   <= cnt_r + 1'b1;
        match_r <= 1'b0;
      end else if (cnt_r == cmp_buf_r) begin
        match_r <= 1'b1;
      end
    end
  end

  // Half-rate output stage
  always_comb begin
    if (wr_cnt) begin
      div_nxt = ctl_r[CTL_EDGE]; // RULE10
    end else if (cmp_pulse) begin
      div_nxt = ~div_r; // RULE9
    end else begin
      div_nxt = div_r;
    end
  end
  // Selected output edge: rising when edge select is 1, else falling
  assign sel_edge = (div_nxt != div_r) && (div_nxt == ctl_r[CTL_EDGE]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r     <= 1'b0;
      oe_sync_r <= 1'b0;
    end else if (clk_en) begin
      div_r <= div_nxt;
      // Enable follows only at the chosen edge, so no runt pulse
      if (sel_edge) begin
        oe_sync_r <= ctl_r[CTL_OE]; // RULE11
      end
    end
  end

  // Pin drive: clock when on, latch when idle and an output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_output_o  <= 1'b0;
      event_output_oe <= 1'b0;
    end else if (clk_en) begin
      event_output_oe <= port_r[PRT_OUT_DIR] | oe_sync_r; // RULE12
      event_output_o  <= oe_sync_r ? div_nxt
                                   : port_r[PRT_LATCH]; // RULE13
    end
  end

  // Event flag; a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      evt_flag_r <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (!ctl_r[CTL_MODE] && act_edge) begin
        evt_flag_r <= 1'b1; // RULE4
      end else if (ctl_r[CTL_MODE] && trail_edge) begin
        evt_flag_r <= 1'b1; // RULE6
      end else if (hit(ADDR_STATUS) && reg_wdata[STS_EVT_CLR]) begin
        evt_flag_r <= 1'b0; // RULE18
      end
      if (cmp_pulse) begin
        cmp_flag_r <= 1'b1;
      end else if (hit(ADDR_STATUS) && reg_wdata[STS_CMP_CLR]) begin
        cmp_flag_r <= 1'b0;
      end
    end
  end

  // Interrupt outputs, registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      input_irq   <= 1'b0;
      compare_irq <= 1'b0;
    end else if (clk_en) begin
      input_irq   <= evt_flag_r & ctl_r[CTL_IRQ_EN]; // RULE19
      compare_irq <= cmp_flag_r & ctl_r[CTL_CMP_IE];
    end
  end

  // Control registers; reserved control bit 5 stays zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rate_r <= 2'b00; // RULE1
      ctl_r  <= RST_ZERO;
      port_r <= 3'b000;
      cmp_r  <= '0;
    end else if (clk_en) begin
      if (hit(ADDR_TIMEBASE)) begin
        rate_r <= reg_wdata[RATE_MSB:RATE_LSB];
      end
      if (hit(ADDR_CONTROL)) begin
        ctl_r <= reg_wdata & 8'hDF;
      end
      if (hit(ADDR_PORT)) begin
        port_r <= reg_wdata[2:0]; // Input direction is software's duty
      end
      if (hit(ADDR_COMPARE)) begin
        cmp_r <= reg_wdata[WIDTH-1:0];
      end
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= RST_ZERO;
    end else if (clk_en) begin
      reg_rdata <= RST_ZERO;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_TIMEBASE: reg_rdata <= {6'h00, rate_r};
          ADDR_CONTROL:  reg_rdata <= ctl_r;
          ADDR_STATUS:   reg_rdata <= {evt_flag_r, cmp_flag_r, 6'h00};
          ADDR_COUNTER:  reg_rdata <= 8'(cnt_r);
          ADDR_COMPARE:  reg_rdata <= 8'(cmp_r);
          ADDR_PORT:     reg_rdata <= {5'h00, port_r};
          default:       reg_rdata <= RST_ZERO;
        endcase
      end
    end
  end

endmodule

// file: hw/tmr2_pkg.sv
package tmr2_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_TIMEBASE = 3'h0; // timebase_control_one
  localparam logic [2:0] ADDR_CONTROL  = 3'h1; // second_timer_control
  localparam logic [2:0] ADDR_STATUS   = 3'h2; // flag and clear bits
  localparam logic [2:0] ADDR_COUNTER  = 3'h3; // second_timer_counter
  localparam logic [2:0] ADDR_COMPARE  = 3'h4; // compare value
  localparam logic [2:0] ADDR_PORT     = 3'h5; // pin direction and latch
  // timebase_control_one fields
  localparam int RATE_LSB = 0;               // rate_select_low
  localparam int RATE_MSB = 1;               // rate_select_high
  // second_timer_control fields
  localparam int CTL_IRQ_EN  = 7;            // input_irq_enable
  localparam int CTL_CMP_IE  = 6;            // compare irq enable
  localparam int CTL_SRC     = 4;            // counter_source_select
  localparam int CTL_MODE    = 3;            // input_mode_select
  localparam int CTL_POL     = 2;            // input_polarity_select
  localparam int CTL_OE      = 1;            // output_enable_bit
  localparam int CTL_EDGE    = 0;            // output_edge_select
  // Status fields
  localparam int STS_EVT     = 7;            // input_event_flag
  localparam int STS_CMP     = 6;            // compare flag
  localparam int STS_EVT_CLR = 3;            // input_flag_clear
  localparam int STS_CMP_CLR = 2;            // compare flag clear
  // Port register fields
  localparam int PRT_IN_DIR  = 0;            // input_pin_direction
  localparam int PRT_OUT_DIR = 1;            // output_pin_direction
  localparam int PRT_LATCH   = 2;            // output_pin_port_latch
  // Reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] CNT_PRESET  = 8'h01;
  // Prescaler taps: divide by 4, 32, 256; rate 0 toggles pclk_r instead, dividing by 2
  localparam int DIV_BITS    = 8;
  localparam int TAP_DIV4    = 1;
  localparam int TAP_DIV32   = 4;
  localparam int TAP_DIV256  = 7;
  localparam int TAP_FIXED   = 1;            // fixed_timer_clock, divide by 4
  // Clock phase states of the timer clock edge detector
  typedef enum logic [1:0] {
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } phase_t;
endpackage

// file: bench/tmr2_monitor.sv
module tmr2_monitor
  import tmr2_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and requests
  input wire logic       event_output_oe,
  input wire logic       fixed_timer_clock,
  input wire logic       input_irq,
  input wire logic       compare_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two high cycles then two low: the divide-by-four wave
  sequence fix_half;
    fixed_timer_clock[*2] ##1 !fixed_timer_clock[*2];
  endsequence
  reset_clear_a: assert property (@(posedge core_clk)
    rst |=> reg_rdata == RST_ZERO && !event_output_oe && !input_irq
      && !compare_irq && !fixed_timer_clock)
    else $error("outputs not cleared by reset");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(reg_rd) |-> reg_rdata == RST_ZERO)
    else $error("read data outside its slot");
  ctl_rsvd_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == ADDR_CONTROL |-> !reg_rdata[5])
    else $error("reserved control bit reads one");
  sts_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == ADDR_STATUS
      |-> reg_rdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) > ADDR_PORT |-> reg_rdata == RST_ZERO)
    else $error("unmapped read not zero");
  fixed_period_a: assert property (@(posedge core_clk)
    disable iff (rst)
    $rose(fixed_timer_clock) |-> fix_half ##1 fixed_timer_clock)
    else $error("fixed clock not a divide by four");
  oe_dir_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == ADDR_PORT && reg_wdata[PRT_OUT_DIR]
      |-> ##[1:2] event_output_oe)
    else $error("pin buffer off with direction set");
  irq_masked_a: assert property (@(posedge core_clk)
    disable iff (rst)
    reg_wr && reg_addr == ADDR_CONTROL && !reg_wdata[CTL_IRQ_EN]
      |-> ##2 !input_irq)
    else $error("input request while disabled");
endmodule

bind timer2_clock_event_io tmr2_monitor mon_u (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .event_output_oe(event_output_oe),
  .fixed_timer_clock(fixed_timer_clock), .input_irq(input_irq),
  .compare_irq(compare_irq)
);

// file: bench/event_far_side.sv
module event_far_side (
  // Level that the bench asks for
  input  wire logic lvl,
  // Event pin into the timer
  output logic      event_input,
  // Shared output pin; the board has no pull on it
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output wire       pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle high before the bench speaks; one process owns the level
  // Source is unrelated to the core clock; levels last many cycles
  initial begin
    event_input = 1'b1;
    forever @(lvl) event_input <= #(1 + $urandom % 7) lvl;
  end
  // Released pin floats instead of holding its last value
  assign pin = pin_oe ? pin_o : 1'bz;
endmodule

// file: bench/tb.sv
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  import tmr2_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench drives, timer outputs and the resolved pin
  logic       core_clk, rst, clk_en, reg_wr, reg_rd, lvl;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic       event_input, event_output_o, event_output_oe;
  logic       fixed_timer_clock, input_irq, compare_irq;
  wire        pin;
  int         n_errors, n_compared, h2, h3, k, q, e;

  timer2_clock_event_io dut_u (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_input(event_input), .event_output_o(event_output_o),
    .event_output_oe(event_output_oe),
    .fixed_timer_clock(fixed_timer_clock), .input_irq(input_irq),
    .compare_irq(compare_irq));
  event_far_side far_u (.lvl(lvl), .event_input(event_input),
    .pin_o(event_output_o), .pin_oe(event_output_oe), .pin(pin));

  // 125 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle write strobe, launched after an edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Cycles until the output pin changes; a stuck pin ends the run
  task automatic half(output int n);
    logic v;
    #1 v = event_output_o;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (event_output_o === v && n < 300);
    if (n >= 300) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic wait_oe(input logic v);
    for (int i = 0; event_output_oe !== v; i++) begin
      @(posedge core_clk);
      #1 if (i > 300) begin
        n_errors++;
        report_and_stop();
      end
    end
  endtask

  // Counts expected from k gated cycles at rate code r
  function automatic int steps(int k, int r);
    return k >> ((r == 0) ? 1 : (r == 1) ? 2 : (r == 2) ? 5 : 8);
  endfunction

  // Hang guard at 90000 cycles, far beyond the length of the run
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    lvl = 1'b1;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(75));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // Reset contents of every index; counter first, before it steps
    for (int i = 0; i < 8; i++) begin
      rd(3'(i + 3), d);
      `CHK(d, (i == 0) ? CNT_PRESET : RST_ZERO)
    end
    // Random traffic; reserved and unmapped places stay zero
    repeat (8) begin
      k = $urandom;
      wr(ADDR_TIMEBASE, k[7:0]);
      rd(ADDR_TIMEBASE, d);
      `CHK(d[1:0], k[1:0])
      wr(ADDR_CONTROL, k[15:8]);
      rd(ADDR_CONTROL, d);
      `CHK(d, k[15:8] & 8'hDF)
      wr(3'h6, k[23:16]);
      rd(3'h6, d);
      `CHK(d, RST_ZERO)
    end
    wr(ADDR_PORT, 8'h00);
    // Event mode, both polarities; input pin direction left clear
    for (int p = 0; p < 2; p++) begin
      lvl <= ~p[0];
      wr(ADDR_CONTROL, {5'b10010, p[0], 2'b00});
      wr(ADDR_COUNTER, RST_ZERO);
      wr(ADDR_STATUS, 8'h08);
      lvl <= p[0];
      repeat (8) @(posedge core_clk);
      rd(ADDR_STATUS, d);
      `CHK(d[STS_EVT], 1'b1)
      `CHK(input_irq, 1'b1)
      rd(ADDR_COUNTER, d);
      `CHK(d, 8'h02)
      wr(ADDR_STATUS, 8'h00);
      lvl <= ~p[0];
      repeat (8) @(posedge core_clk);
      rd(ADDR_COUNTER, d);
      `CHK(d, 8'h02)
      rd(ADDR_STATUS, d);
      `CHK(d[STS_EVT], 1'b1)
      wr(ADDR_STATUS, 8'h08);
      rd(ADDR_STATUS, d);
      `CHK(d[STS_EVT], 1'b0)
    end
    // Gate mode at every rate with random polarity and width
    for (int r = 0; r < 4; r++) begin
      k = 32 + $urandom % 64;
      q = $urandom % 2;
      wr(ADDR_TIMEBASE, r[7:0]);
      lvl <= ~q[0];
      wr(ADDR_CONTROL, {5'b10011, q[0], 2'b00});
      wr(ADDR_COUNTER, RST_ZERO);
      wr(ADDR_STATUS, 8'h08);
      lvl <= q[0];
      repeat (k) @(posedge core_clk);
      `CHK(input_irq, 1'b0)
      lvl <= ~q[0];
      repeat (8) @(posedge core_clk);
      e = 1 + steps(k, r);
      rd(ADDR_COUNTER, d);
      `CHK(d >= e - 1 && d <= e + 1, 1'b1)
      rd(ADDR_STATUS, d);
      `CHK(d[STS_EVT], 1'b1)
    end
    // Idle pin: latch when direction set, floating otherwise
    wr(ADDR_PORT, 8'h06);
    @(posedge core_clk);
    #1 `CHK(pin, 1'b1)
    wr(ADDR_PORT, 8'h02);
    @(posedge core_clk);
    #1 `CHK(pin, 1'b0)
    wr(ADDR_PORT, 8'h00);
    @(posedge core_clk);
    #1 `CHK(pin, 1'bz)
    // Output clock with each edge select
    wr(ADDR_TIMEBASE, 8'h00);
    wr(ADDR_COMPARE, 8'h03);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CONTROL, {2'b01, 4'h0, 1'b1, s[0]});
      wr(ADDR_STATUS, 8'h04);
      wr(ADDR_COUNTER, RST_ZERO);
      wait_oe(1'b1);
      `CHK(event_output_o, s[0])
      half(h2);
      half(h2);
      half(h3);
      `CHK(h2, h3)
      `CHK(h3, 6)
      `CHK(compare_irq, 1'b1)
      wr(ADDR_COUNTER, RST_ZERO);
      #1 `CHK(event_output_o, s[0])
      wr(ADDR_CONTROL, {7'h00, s[0]});
      wait_oe(1'b0);
      `CHK(pin, 1'bz)
    end
    report_and_stop();
  end
endmodule
